// ---- serial_rx_pkg.sv ----
// Operation
// - Buffered character sets receive-complete, may interrupt
// - Address detect with nine-bit reception keeps only ninth-bit-set characters
// - Address detect acts only in nine-bit reception, where buffered characters read ninth bit one
// - No address detect: every character is buffered
// - Clearing continuous enable clears overrun flag
// - Clearing port enable flushes the buffer, clears overrun and idles the receive engine
// - Port active only when enabled; async needs sync clear
// - Reception needs continuous enable with port enabled
// - Ninth received bit reported in status register
// - Data register returns oldest character's low byte
// - Framing and overrun flags readable in status
// - Sync slave: sync, enable set, clock source clear
// - Sync slave receives only with continuous enable; single enable ignored
// - Sync slave completes characters and wakes in Sleep
// - Sync slave sets receive-complete after full character
// - Bit rate from divisor pair, speed and width
// - Sync slave otherwise matches sync master reception
package serial_rx_pkg;

  // Byte addresses of the register words
  localparam logic [4:0] ADDR_RX_STATUS = 5'h00;
  localparam logic [4:0] ADDR_RX_DATA = 5'h04;
  localparam logic [4:0] ADDR_TX_STATUS = 5'h08;
  localparam logic [4:0] ADDR_BAUD_CTRL = 5'h0C;
  localparam logic [4:0] ADDR_DIV_LOW = 5'h10;
  localparam logic [4:0] ADDR_DIV_HIGH = 5'h14;
  localparam logic [4:0] ADDR_INT_CTRL = 5'h18;

  // receive_status_control fields
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINTH_EN = 6;
  localparam int RS_SINGLE_EN = 5;
  localparam int RS_CONT_EN = 4;
  localparam int RS_ADDR_EN = 3;
  localparam int RS_FRAME_ERR = 2;
  localparam int RS_OVERRUN = 1;
  localparam int RS_NINTH_BIT = 0;

  // transmit_status_control fields
  localparam int TS_CLOCK_SRC = 7;
  localparam int TS_SYNC_MODE = 4;
  localparam int TS_HIGH_SPEED = 2;

  // baud_control fields
  localparam int BC_IDLE = 6;
  localparam int BC_CLK_POL = 4;
  localparam int BC_WIDE_GEN = 3;

  // Interrupt control word fields
  localparam int IC_INT_EN = 0;
  localparam int IC_COMPLETE = 1;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Baud prescale shifts: 64, 16, 16 and 4 clocks per divisor step
  localparam logic [2:0] SHIFT_NARROW_LOW = 3'h6;
  localparam logic [2:0] SHIFT_MID = 3'h4;
  localparam logic [2:0] SHIFT_WIDE_HIGH = 3'h2;

  // Last data bit index for eight and nine bit characters
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  // Receive buffer depth
  localparam int RX_DEPTH = 2;

  typedef struct packed {
    logic frameErr;
    logic ninth;
    logic [7:0] data;
  } rx_char_t;

  localparam int CHAR_W = $bits(rx_char_t);

endpackage

// ---- rx_fifo.sv ----
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic flush,
  // Fill side
  input wire logic pushValid,
  output logic pushReady,
  input wire logic [WIDTH-1:0] pushData,
  // Drain side
  output logic popValid,
  input wire logic popReady,
  output logic [WIDTH-1:0] popData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : gBadParams
    $error("rx_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic doPush;
  logic doPop;

  assign pushReady = (count_q != (AW+1)'(DEPTH));
  assign popValid = (count_q != '0);
  assign popData = mem[rdPtr_q];
  assign doPush = pushValid & pushReady;
  assign doPop = popValid & popReady;

  always_ff @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr_q] <= pushData;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (doPush && !doPop) begin
        count_q <= count_q + 1'b1;
      end else if (doPop && !doPush) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ---- serial_receiver.sv ----
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module serial_receiver
  import serial_rx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial pins
  input wire logic serialDataLine,
  input wire logic serialClockLine,
  // Power state and requests
  input wire logic sleepMode,
  output logic receiveIrq,
  output logic wakeRequest
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  // Control registers
  logic portEnable_q;
  logic ninthEnable_q;
  logic singleEnable_q;
  logic contEnable_q;
  logic addrEnable_q;
  logic clockSource_q;
  logic syncMode_q;
  logic highSpeed_q;
  logic clkPolarity_q;
  logic wideGen_q;
  logic [7:0] divLow_q;
  logic [7:0] divHigh_q;
  logic intEnable_q;

  // Bus handshake
  logic ack_q;
  logic [31:0] readdata_q;
  logic wrAcc;
  logic rdAcc;

  // Pin synchronisers
  logic dataMeta_q;
  logic dataSync_q;
  logic clkMeta_q;
  logic clkSync_q;
  logic clkPrev_q;

  // Receive engine
  rx_state_t state_q;
  logic [23:0] cnt_q;
  logic [3:0] bitIdx_q;
  logic [8:0] shift_q;
  logic done_q;
  rx_char_t doneChar_q;
  logic overrun_q;
  logic irq_q;
  logic wake_q;

  // Derived control
  logic asyncMode;
  logic slaveMode;
  logic rxEnable;
  logic [15:0] divisor;
  logic [2:0] rateShift;
  logic [23:0] bitPeriod;
  logic [23:0] halfPeriod;
  logic sampleEdge;
  logic [3:0] lastBit;
  logic keepChar;
  rx_char_t newChar;

  // Buffer
  logic pushReady;
  logic popValid;
  rx_char_t head;

  assign asyncMode = portEnable_q & ~syncMode_q;
  assign slaveMode = portEnable_q & syncMode_q & ~clockSource_q;
  // Single enable takes no part in slave reception
  assign rxEnable = contEnable_q & (asyncMode | slaveMode);

  // Bit period in clocks
  always_comb begin
    divisor = wideGen_q ? {divHigh_q, divLow_q} : {8'h00, divLow_q};
    if (wideGen_q && highSpeed_q) begin
      rateShift = SHIFT_WIDE_HIGH;
    end else if (wideGen_q || highSpeed_q) begin
      rateShift = SHIFT_MID;
    end else begin
      rateShift = SHIFT_NARROW_LOW;
    end
    bitPeriod = (24'(divisor) + 24'h000001) << rateShift;
    halfPeriod = bitPeriod >> 1;
  end

  assign lastBit = ninthEnable_q ? LAST_BIT_9 : LAST_BIT_8;
  assign sampleEdge = clkPolarity_q ? (~clkPrev_q & clkSync_q) : (clkPrev_q & ~clkSync_q);

  // Character assembled from the shifter
  always_comb begin
    newChar = '0;
    if (ninthEnable_q) begin
      newChar.data = shift_q[7:0];
      newChar.ninth = shift_q[8];
    end else begin
      newChar.data = shift_q[8:1];
      newChar.ninth = 1'b0;
    end
  end

  // Bus handshake: one wait cycle per access
  assign waitrequest = (read | write) & ~ack_q;
  assign wrAcc = write & ack_q & byteenable[0];
  assign rdAcc = read & ack_q;
  assign readdata = readdata_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // Read data capture
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readdata_q <= '0;
    end else if (read && !ack_q) begin
      readdata_q <= '0;
      if (address == ADDR_RX_STATUS) begin
        readdata_q[RS_PORT_EN] <= portEnable_q;
        readdata_q[RS_NINTH_EN] <= ninthEnable_q;
        readdata_q[RS_SINGLE_EN] <= singleEnable_q;
        readdata_q[RS_CONT_EN] <= contEnable_q;
        readdata_q[RS_ADDR_EN] <= addrEnable_q;
        readdata_q[RS_FRAME_ERR] <= popValid & head.frameErr;
        readdata_q[RS_OVERRUN] <= overrun_q;
        readdata_q[RS_NINTH_BIT] <= popValid & head.ninth;
      end else if (address == ADDR_RX_DATA) begin
        readdata_q[7:0] <= popValid ? head.data : 8'h00;
      end else if (address == ADDR_TX_STATUS) begin
        readdata_q[TS_CLOCK_SRC] <= clockSource_q;
        readdata_q[TS_SYNC_MODE] <= syncMode_q;
        readdata_q[TS_HIGH_SPEED] <= highSpeed_q;
      end else if (address == ADDR_BAUD_CTRL) begin
        readdata_q[BC_IDLE] <= (state_q == RX_IDLE);
        readdata_q[BC_CLK_POL] <= clkPolarity_q;
        readdata_q[BC_WIDE_GEN] <= wideGen_q;
      end else if (address == ADDR_DIV_LOW) begin
        readdata_q[7:0] <= divLow_q;
      end else if (address == ADDR_DIV_HIGH) begin
        readdata_q[7:0] <= divHigh_q;
      end else if (address == ADDR_INT_CTRL) begin
        readdata_q[IC_INT_EN] <= intEnable_q;
        readdata_q[IC_COMPLETE] <= popValid;
      end
    end
  end

  // Register writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      portEnable_q <= RESET_BYTE[RS_PORT_EN];
      ninthEnable_q <= RESET_BYTE[RS_NINTH_EN];
      singleEnable_q <= RESET_BYTE[RS_SINGLE_EN];
      contEnable_q <= RESET_BYTE[RS_CONT_EN];
      addrEnable_q <= RESET_BYTE[RS_ADDR_EN];
      clockSource_q <= RESET_BYTE[TS_CLOCK_SRC];
      syncMode_q <= RESET_BYTE[TS_SYNC_MODE];
      highSpeed_q <= RESET_BYTE[TS_HIGH_SPEED];
      clkPolarity_q <= RESET_BYTE[BC_CLK_POL];
      wideGen_q <= RESET_BYTE[BC_WIDE_GEN];
      divLow_q <= RESET_BYTE;
      divHigh_q <= RESET_BYTE;
      intEnable_q <= RESET_BYTE[IC_INT_EN];
    end else if (wrAcc) begin
      if (address == ADDR_RX_STATUS) begin
        portEnable_q <= writedata[RS_PORT_EN];
        ninthEnable_q <= writedata[RS_NINTH_EN];
        singleEnable_q <= writedata[RS_SINGLE_EN];
        contEnable_q <= writedata[RS_CONT_EN];
        addrEnable_q <= writedata[RS_ADDR_EN];
      end else if (address == ADDR_TX_STATUS) begin
        clockSource_q <= writedata[TS_CLOCK_SRC];
        syncMode_q <= writedata[TS_SYNC_MODE];
        highSpeed_q <= writedata[TS_HIGH_SPEED];
      end else if (address == ADDR_BAUD_CTRL) begin
        clkPolarity_q <= writedata[BC_CLK_POL];
        wideGen_q <= writedata[BC_WIDE_GEN];
      end else if (address == ADDR_DIV_LOW) begin
        divLow_q <= writedata[7:0];
      end else if (address == ADDR_DIV_HIGH) begin
        divHigh_q <= writedata[7:0];
      end else if (address == ADDR_INT_CTRL) begin
        intEnable_q <= writedata[IC_INT_EN];
      end
    end
  end

  // Two-stage pin synchronisers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dataMeta_q <= 1'b1;
      dataSync_q <= 1'b1;
      clkMeta_q <= 1'b0;
      clkSync_q <= 1'b0;
      clkPrev_q <= 1'b0;
    end else begin
      dataMeta_q <= serialDataLine;
      dataSync_q <= dataMeta_q;
      clkMeta_q <= serialClockLine;
      clkSync_q <= clkMeta_q;
      clkPrev_q <= clkSync_q;
    end
  end

  // Receive engine; runs regardless of sleepMode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RX_IDLE;
      cnt_q <= '0;
      bitIdx_q <= '0;
      shift_q <= '0;
      done_q <= 1'b0;
      doneChar_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (!rxEnable || overrun_q) begin
        state_q <= RX_IDLE;
        cnt_q <= '0;
        bitIdx_q <= '0;
      end else if (slaveMode) begin
        // Slave: one bit per falling external clock edge (rising with clock polarity set), LSB first
        if (sampleEdge) begin
          shift_q <= {dataSync_q, shift_q[8:1]};
          state_q <= RX_DATA;
          if (bitIdx_q == lastBit) begin
            bitIdx_q <= '0;
            state_q <= RX_IDLE;
            done_q <= 1'b1;
            doneChar_q <= '0;
            if (ninthEnable_q) begin
              doneChar_q.data <= shift_q[8:1];
              doneChar_q.ninth <= dataSync_q;
            end else begin
              doneChar_q.data <= {dataSync_q, shift_q[8:2]};
            end
          end else begin
            bitIdx_q <= bitIdx_q + 4'h1;
          end
        end
      end else begin
        case (state_q)
          RX_IDLE: begin
            cnt_q <= '0;
            bitIdx_q <= '0;
            if (!dataSync_q) begin
              state_q <= RX_START;
            end
          end
          RX_START: begin
            cnt_q <= cnt_q + 24'h000001;
            if (cnt_q == halfPeriod - 24'h000001) begin
              cnt_q <= '0;
              state_q <= dataSync_q ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            cnt_q <= cnt_q + 24'h000001;
            if (cnt_q == bitPeriod - 24'h000001) begin
              cnt_q <= '0;
              shift_q <= {dataSync_q, shift_q[8:1]};
              bitIdx_q <= bitIdx_q + 4'h1;
              if (bitIdx_q == lastBit) begin
                state_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            cnt_q <= cnt_q + 24'h000001;
            if (cnt_q == bitPeriod - 24'h000001) begin
              state_q <= RX_IDLE;
              done_q <= 1'b1;
              doneChar_q <= newChar;
              doneChar_q.frameErr <= ~dataSync_q;
            end
          end
          default: begin
            state_q <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // Address filter on completed characters
  assign keepChar = ~(ninthEnable_q & addrEnable_q) | doneChar_q.ninth;

  // Overrun flag
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      overrun_q <= 1'b0;
    end else if (done_q && keepChar && !pushReady) begin
      overrun_q <= 1'b1;
    end else if (!contEnable_q || !portEnable_q) begin
      overrun_q <= 1'b0;
    end
  end

  // Receive-complete request and wake
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= popValid & intEnable_q;
      wake_q <= sleepMode & popValid & intEnable_q;
    end
  end

  assign receiveIrq = irq_q;
  assign wakeRequest = wake_q;

  // Two-entry receive buffer, flushed while the port is off
  rx_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(RX_DEPTH)
  ) uFifo (
    .mclk(mclk),
    .rstn(rstn),
    .flush(~portEnable_q),
    .pushValid(done_q & keepChar & ~overrun_q),
    .pushReady(pushReady),
    .pushData(doneChar_q),
    .popValid(popValid),
    .popReady(rdAcc && address == ADDR_RX_DATA),
    .popData(head)
  );
endmodule

// ---- serial_receiver_sva.sv ----
`timescale 1ns/1ps
module serial_receiver_sva
  import serial_rx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bus
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins and power
  input wire logic serialDataLine,
  input wire logic serialClockLine,
  input wire logic sleepMode,
  input wire logic receiveIrq,
  input wire logic wakeRequest
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  property p_waitFirst;
    (read || write) && !$past(read || write) |-> waitrequest;
  endproperty
  a_waitFirst: assert property (p_waitFirst) else $error("no wait cycle");
  property p_waitOne;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_waitOne: assert property (p_waitOne) else $error("wait too long");
  property p_noWaitIdle;
    !(read || write) |-> !waitrequest;
  endproperty
  a_noWaitIdle: assert property (p_noWaitIdle) else $error("wait while idle");
  property p_unmapped;
    read && !waitrequest && address == 5'h1C |-> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_byteLane;
    read && !waitrequest |-> readdata[31:8] == 24'h0;
  endproperty
  a_byteLane: assert property (p_byteLane) else $error("upper lanes not zero");
  property p_wakeIrq;
    wakeRequest |-> receiveIrq;
  endproperty
  a_wakeIrq: assert property (p_wakeIrq) else $error("wake without request");
  property p_wakeSleep;
    $rose(wakeRequest) |-> $past(sleepMode);
  endproperty
  a_wakeSleep: assert property (p_wakeSleep) else $error("wake outside sleep");
  property p_irqDrop;
    $fell(receiveIrq) |-> $past(read || write, 2) || $past(read || write, 3);
  endproperty
  a_irqDrop: assert property (p_irqDrop) else $error("request dropped alone");
endmodule

bind serial_receiver serial_receiver_sva u_serial_receiver_sva (.mclk(mclk), .rstn(rstn),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .serialDataLine(serialDataLine), .serialClockLine(serialClockLine),
  .sleepMode(sleepMode), .receiveIrq(receiveIrq), .wakeRequest(wakeRequest));

// ---- serial_peer.sv ----
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic mclk,
  // Lines
  output logic dataLine,
  output logic clockLine
);
  initial begin
    dataLine = 1'b1;
    clockLine = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Async frame, line pulled high after stop
  task automatic sendAsync(input logic [8:0] v, input int nb, input logic stopBit, input int per);
    dataLine <= 1'b0;
    hold(per);
    for (int i = 0; i < nb; i++) begin
      dataLine <= v[i];
      hold(per);
    end
    dataLine <= stopBit;
    hold(per * 3 / 4);
    dataLine <= 1'b1;
    hold(per + per / 4);
  endtask
  // Sync master clocking, clock idle low
  task automatic sendSync(input logic [8:0] v, input int nb);
    for (int i = 0; i < nb; i++) begin
      dataLine <= v[i];
      hold(4);
      clockLine <= 1'b1;
      hold(4);
      clockLine <= 1'b0;
      hold(4);
    end
    dataLine <= ~v[nb-1];
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import serial_rx_pkg::*;
  logic mclk;
  logic rstn;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic serialDataLine;
  logic serialClockLine;
  logic sleepMode;
  logic receiveIrq;
  logic wakeRequest;
  logic [31:0] rd;
  int mismatches;
  int n_checks;
  int cycles;

  serial_receiver u_serial_receiver (.mclk(mclk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .serialDataLine(serialDataLine),
    .serialClockLine(serialClockLine), .sleepMode(sleepMode), .receiveIrq(receiveIrq),
    .wakeRequest(wakeRequest));
  serial_peer u_serial_peer (.mclk(mclk), .dataLine(serialDataLine),
    .clockLine(serialClockLine));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic busXfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] be);
    @(posedge mclk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    busXfer(1'b1, a, {24'h0, d}, 4'hF);
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
    busXfer(1'b0, a, 32'h0, 4'hF);
    checkWord(rd, {24'h0, e});
  endtask

  task automatic waitFor(input int n);
    for (int i = 0; i < n && receiveIrq !== 1'b1; i++) @(posedge mclk);
  endtask

  task automatic resetRegs();
    rdChk(ADDR_RX_STATUS, 8'h00);
    rdChk(ADDR_RX_DATA, 8'h00);
    rdChk(ADDR_INT_CTRL, 8'h00);
    rdChk(ADDR_BAUD_CTRL, 8'h40);
    wr(5'h1C, 8'hFF);
    rdChk(5'h1C, 8'h00);
    busXfer(1'b1, ADDR_RX_STATUS, 32'h90, 4'h0);
    rdChk(ADDR_RX_STATUS, 8'h00);
  endtask

  task automatic asyncBasic();
    wr(ADDR_INT_CTRL, 8'h01);
    wr(ADDR_RX_STATUS, 8'h80);
    u_serial_peer.sendAsync(9'h0A5, 8, 1'b1, 64);
    rdChk(ADDR_INT_CTRL, 8'h01);
    wr(ADDR_TX_STATUS, 8'h04);
    wr(ADDR_DIV_LOW, 8'h01);
    wr(ADDR_DIV_HIGH, 8'h01);
    rdChk(ADDR_DIV_HIGH, 8'h01);
    wr(ADDR_RX_STATUS, 8'h90);
    u_serial_peer.sendAsync(9'h0A5, 8, 1'b1, 32);
    waitFor(200);
    checkWord({31'h0, receiveIrq}, 32'h1);
    rdChk(ADDR_INT_CTRL, 8'h03);
    rdChk(ADDR_RX_STATUS, 8'h90);
    rdChk(ADDR_RX_DATA, 8'hA5);
    rdChk(ADDR_INT_CTRL, 8'h01);
    wr(ADDR_BAUD_CTRL, 8'h08);
    rdChk(ADDR_BAUD_CTRL, 8'h48);
    wr(ADDR_DIV_HIGH, 8'h00);
    wr(ADDR_DIV_LOW, 8'h07);
    u_serial_peer.sendAsync(9'h0E1, 8, 1'b1, 32);
    rdChk(ADDR_RX_DATA, 8'hE1);
    wr(ADDR_BAUD_CTRL, 8'h00);
    wr(ADDR_TX_STATUS, 8'h00);
    wr(ADDR_DIV_LOW, 8'h00);
  endtask

  task automatic framing();
    u_serial_peer.sendAsync(9'h03C, 8, 1'b0, 64);
    waitFor(200);
    rdChk(ADDR_RX_STATUS, 8'h94);
    rdChk(ADDR_RX_DATA, 8'h3C);
  endtask

  task automatic addrMode();
    wr(ADDR_RX_STATUS, 8'hD8);
    u_serial_peer.sendAsync(9'h055, 9, 1'b1, 64);
    rdChk(ADDR_INT_CTRL, 8'h01);
    u_serial_peer.sendAsync(9'h1C3, 9, 1'b1, 64);
    waitFor(200);
    rdChk(ADDR_RX_STATUS, 8'hD9);
    rdChk(ADDR_RX_DATA, 8'hC3);
    wr(ADDR_RX_STATUS, 8'hD0);
    u_serial_peer.sendAsync(9'h042, 9, 1'b1, 64);
    waitFor(200);
    rdChk(ADDR_RX_STATUS, 8'hD0);
    rdChk(ADDR_RX_DATA, 8'h42);
  endtask

  task automatic overrun();
    wr(ADDR_RX_STATUS, 8'h90);
    for (int i = 1; i < 4; i++) u_serial_peer.sendAsync(9'(i), 8, 1'b1, 64);
    rdChk(ADDR_RX_STATUS, 8'h92);
    rdChk(ADDR_RX_DATA, 8'h01);
    wr(ADDR_RX_STATUS, 8'h80);
    rdChk(ADDR_RX_STATUS, 8'h80);
    rdChk(ADDR_RX_DATA, 8'h02);
    wr(ADDR_RX_STATUS, 8'h90);
    for (int i = 4; i < 7; i++) u_serial_peer.sendAsync(9'(i), 8, 1'b1, 64);
    wr(ADDR_RX_STATUS, 8'h10);
    rdChk(ADDR_RX_STATUS, 8'h10);
    rdChk(ADDR_RX_DATA, 8'h00);
  endtask

  task automatic syncSlave();
    wr(ADDR_TX_STATUS, 8'h90);
    wr(ADDR_RX_STATUS, 8'hB0);
    u_serial_peer.sendSync(9'h096, 8);
    rdChk(ADDR_INT_CTRL, 8'h01);
    wr(ADDR_TX_STATUS, 8'h10);
    u_serial_peer.sendSync(9'h096, 8);
    waitFor(50);
    rdChk(ADDR_RX_DATA, 8'h96);
    wr(ADDR_BAUD_CTRL, 8'h10);
    u_serial_peer.sendSync(9'h0C7, 8);
    waitFor(50);
    rdChk(ADDR_RX_DATA, 8'hC7);
    wr(ADDR_BAUD_CTRL, 8'h00);
    sleepMode <= 1'b1;
    u_serial_peer.sendSync(9'h05A, 8);
    waitFor(50);
    checkWord({31'h0, wakeRequest}, 32'h1);
    sleepMode <= 1'b0;
    rdChk(ADDR_RX_DATA, 8'h5A);
  endtask

  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    sleepMode = 1'b0;
    cycles = 0;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    resetRegs();
    asyncBasic();
    framing();
    addrMode();
    overrun();
    syncSlave();
    test_done();
  end
endmodule
